// file: uml_regs.vh
`ifndef UML_REGS_VH
`define UML_REGS_VH

// ==========================================================================
// Register byte addresses on the Wishbone slave.
// ==========================================================================
`define UML_ADR_WIDTH          8
`define UML_ADR_MODEM_CONTROL  8'h00
`define UML_ADR_LINE_STATUS    8'h04
`define UML_ADR_MODEM_STATUS   8'h08
`define UML_ADR_SCRATCH        8'h0c
`define UML_ADR_ENH_FEATURE    8'h10

// ==========================================================================
// Modem control fields.
// ==========================================================================
`define UML_MC_TERM_READY      0
`define UML_MC_REQ_SEND        1
`define UML_MC_USER_OUT_ONE    2
`define UML_MC_USER_OUT_TWO    3
`define UML_MC_LOOP_BACK       4
`define UML_MC_XON_ANY         5
`define UML_MC_INFRARED        6
`define UML_MC_PRESCALE_FOUR   7

// ==========================================================================
// Line status fields.
// ==========================================================================
`define UML_LS_DATA_READY      0
`define UML_LS_OVERRUN         1
`define UML_LS_PARITY_ERR      2
`define UML_LS_FRAMING_ERR     3
`define UML_LS_BREAK           4
`define UML_LS_THR_EMPTY       5
`define UML_LS_TX_EMPTY        6
`define UML_LS_FIFO_ERROR      7

// ==========================================================================
// Enhanced feature fields used here.
// ==========================================================================
`define UML_EF_AUTO_RTS        6
`define UML_EF_AUTO_CTS        7

// ==========================================================================
// Reset values.
// ==========================================================================
`define UML_RST_MODEM_CONTROL  8'h00
`define UML_RST_SCRATCH        8'h00
`define UML_RST_ENH_FEATURE    8'h00

// ==========================================================================
// Prescaler ratios.
// ==========================================================================
`define UML_PRESCALE_BASE      7'h10
`define UML_PRESCALE_EXTRA     7'h04

`endif

// file: uml_sync.v
`timescale 1ns/1ps
`include "uml_regs.vh"

module uml_sync #(
	parameter WIDTH = 6,
	parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
	input  wire             mclk,
	input  wire             reset,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] level_out
);

	// ======================================================================
	// Three stages per pin; the output moves only once the last two agree.
	// ======================================================================
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			reg hold_q;
			reg level_q;
			always @(posedge mclk or posedge reset) begin
				if (reset) begin
					meta_q  <= IDLE[i];
					sync_q  <= IDLE[i];
					hold_q  <= IDLE[i];
					level_q <= IDLE[i];
				end else begin
					meta_q <= pin_in[i];
					sync_q <= meta_q;
					hold_q <= sync_q;
					if (sync_q == hold_q) begin
						level_q <= hold_q;
					end
				end
			end
			assign level_out[i] = level_q;
		end
	endgenerate

endmodule

// file: uml_core.v
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "uml_regs.vh"

// Behaviour
// - Control bit 0 drives terminal ready low
// - Control bit 1 drives request-to-send low
// - Control bit 2 gives loop-back ring state
// - Control bit 3 enables interrupt drive, loop carrier
// - Control bit 4 enables local loop-back
// - Control bit 5: any character resumes
// - Control bit 6 routes serial through infrared
// - Prescaler divides by sixteen, optionally four more
// - Status bit 0 shows receive data present
// - Overrun sets flag, character never enters FIFO
// - Status bit 2 is head character parity
// - Status bit 3 is head character framing
// - Status bit 4 break, one character per break
// - Status bit 5 holding empty, clears on load unless thr_to_tsr coincides in non-FIFO mode
// - Status bit 6 holding and shifter empty
// - Status bit 7 FIFO error, cleared by read
// - Modem change bits set on change, read clears
// - Ring change only on trailing edge
// - Any change bit raises modem interrupt request
// - Modem bits 4-7 are inverted pins
// - Loop-back: bits 4-7 mirror control bits
// - Clear-to-send high halts after current character
// - Eight-bit scratch register, no side effects
// - Auto clear-to-send only with feature bit 7
module uml_core (
	input  wire        mclk,
	input  wire        reset,
	// Wishbone classic slave.
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// Modem pins.
	input  wire        clear_to_send_n,
	input  wire        data_set_ready_n,
	input  wire        ring_indicate_n,
	input  wire        carrier_detect_n,
	output wire        terminal_ready_n,
	output wire        request_to_send_n,
	output wire        user_output_one_n,
	output wire        user_output_two_n,
	// Serial pins.
	input  wire        rx_pin,
	input  wire        ir_rx_pin,
	output wire        tx_pin,
	output wire        ir_tx_pin,
	// Channel interrupt pin.
	input  wire        bus_mode_16,
	input  wire        chan_irq_in,
	output wire        chan_irq_out,
	output wire        chan_irq_oe,
	// Shifters, FIFOs and interrupt logic of the channel.
	input  wire        tx_serial,
	output wire        rx_serial,
	input  wire        fifo_mode,
	input  wire        rx_data_present,
	input  wire        rx_char_done,
	input  wire        rx_char_break,
	input  wire        rx_char_error,
	input  wire        rx_fifo_full,
	input  wire        rx_head_parity,
	input  wire        rx_head_framing,
	input  wire        rx_head_break,
	input  wire        rx_rts_stop,
	output wire        rx_fifo_write,
	output wire        xon_any_resume,
	input  wire        thr_load,
	input  wire        thr_to_tsr,
	input  wire        tx_fifo_empty,
	input  wire        tsr_empty,
	input  wire        thr_irq_enable,
	output wire        thr_irq_req,
	output wire        tx_allow,
	output wire        msr_irq_req,
	output wire        prescale_tick
);

	// ======================================================================
	// Bus slave: one wait state, registered acknowledge and read data.
	// ======================================================================
	reg  [7:0]  modem_control_q;
	reg  [7:0]  scratch_q;
	reg  [7:0]  enh_feature_q;
	reg         ack_q;
	reg  [7:0]  rdata_q;
	reg  [7:0]  rdata_d;
	wire [7:0]  line_status;
	wire [7:0]  modem_status;

	wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
	wire        bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
	wire        bus_rd    = bus_req & ~wb_we_i;
	wire        wr_mc     = bus_wr & (wb_adr_i == `UML_ADR_MODEM_CONTROL);
	wire        wr_scr    = bus_wr & (wb_adr_i == `UML_ADR_SCRATCH);
	wire        wr_ef     = bus_wr & (wb_adr_i == `UML_ADR_ENH_FEATURE);
	wire        rd_ls     = bus_rd & (wb_adr_i == `UML_ADR_LINE_STATUS);
	wire        rd_ms     = bus_rd & (wb_adr_i == `UML_ADR_MODEM_STATUS);

	assign wb_ack_o = ack_q;
	assign wb_dat_o = {24'h000000, rdata_q};

	// Unmapped addresses are acknowledged and read as zero.
	always @* begin
		case (wb_adr_i)
			`UML_ADR_MODEM_CONTROL: rdata_d = modem_control_q;
			`UML_ADR_LINE_STATUS:   rdata_d = line_status;
			`UML_ADR_MODEM_STATUS:  rdata_d = modem_status;
			`UML_ADR_SCRATCH:       rdata_d = scratch_q;
			`UML_ADR_ENH_FEATURE:   rdata_d = enh_feature_q;
			default:                rdata_d = 8'h00;
		endcase
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= bus_req;
			if (bus_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			modem_control_q <= `UML_RST_MODEM_CONTROL;
			scratch_q       <= `UML_RST_SCRATCH;
			enh_feature_q   <= `UML_RST_ENH_FEATURE;
		end else begin
			if (wr_mc) begin
				modem_control_q <= wb_dat_i[7:0];
			end
			if (wr_scr) begin
				scratch_q <= wb_dat_i[7:0];
			end
			if (wr_ef) begin
				enh_feature_q <= wb_dat_i[7:0];
			end
		end
	end

	wire loop_on  = modem_control_q[`UML_MC_LOOP_BACK];
	wire ir_on    = modem_control_q[`UML_MC_INFRARED];
	wire auto_cts = enh_feature_q[`UML_EF_AUTO_CTS];
	wire auto_rts = enh_feature_q[`UML_EF_AUTO_RTS];

	// ======================================================================
	// Pin synchronisers.
	// ======================================================================
	wire [5:0] pin_level;

	uml_sync #(
		.WIDTH (6),
		.IDLE  (6'h3f)
	) u_sync (
		.mclk      (mclk),
		.reset     (reset),
		.pin_in    ({ir_rx_pin, rx_pin, carrier_detect_n, ring_indicate_n,
		              data_set_ready_n, clear_to_send_n}),
		.level_out (pin_level)
	);

	// ======================================================================
	// Handshake outputs.
	// ======================================================================
	// In loop-back the pins rest at their inactive level so the peripheral
	// sees nothing while software exercises the path.
	assign terminal_ready_n  = loop_on | ~modem_control_q[`UML_MC_TERM_READY];
	assign request_to_send_n = loop_on | ~modem_control_q[`UML_MC_REQ_SEND] |
	                           (auto_rts & rx_rts_stop);
	assign user_output_one_n = loop_on | ~modem_control_q[`UML_MC_USER_OUT_ONE];
	assign user_output_two_n = loop_on | ~modem_control_q[`UML_MC_USER_OUT_TWO];

	// The 16 bus mode floats the interrupt pin unless bit 3 asks for drive.
	assign chan_irq_out = chan_irq_in;
	assign chan_irq_oe  = ~bus_mode_16 | modem_control_q[`UML_MC_USER_OUT_TWO];

	// ======================================================================
	// Serial routing.
	// ======================================================================
	wire ir_rx_level = pin_level[5];
	wire rx_level    = pin_level[4];

	// Infrared encoding is inverted so the transmit output idles low.
	assign tx_pin    = loop_on | ir_on | tx_serial;
	assign ir_tx_pin = ~loop_on & ir_on & ~tx_serial;
	assign rx_serial = loop_on ? tx_serial :
	                   (ir_on ? ~ir_rx_level : rx_level);

	// ======================================================================
	// Modem status.
	// ======================================================================
	// Internal inputs keep the active-low sense of the pins.
	wire cts_int_n = loop_on ? ~modem_control_q[`UML_MC_REQ_SEND]     : pin_level[0];
	wire dsr_int_n = loop_on ? ~modem_control_q[`UML_MC_TERM_READY]   : pin_level[1];
	wire ri_int_n  = loop_on ? ~modem_control_q[`UML_MC_USER_OUT_ONE] : pin_level[2];
	wire cd_int_n  = loop_on ? ~modem_control_q[`UML_MC_USER_OUT_TWO] : pin_level[3];

	reg  [3:0] prev_in_n_q;
	reg  [3:0] delta_q;
	reg  [3:0] delta_d;
	wire [3:0] cur_in_n = {cd_int_n, ri_int_n, dsr_int_n, cts_int_n};
	wire [3:0] change;

	assign change[0] = cur_in_n[0] ^ prev_in_n_q[0];
	assign change[1] = cur_in_n[1] ^ prev_in_n_q[1];
	assign change[2] = cur_in_n[2] & ~prev_in_n_q[2];
	assign change[3] = cur_in_n[3] ^ prev_in_n_q[3];

	// A change seen in the cycle of a read survives the clear.
	always @* begin
		delta_d = delta_q;
		if (rd_ms) begin
			delta_d = 4'h0;
		end
		delta_d = delta_d | change;
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			prev_in_n_q <= 4'hf;
			delta_q     <= 4'h0;
		end else begin
			prev_in_n_q <= cur_in_n;
			delta_q     <= delta_d;
		end
	end

	assign modem_status = {~cur_in_n, delta_q};
	assign msr_irq_req  = |delta_q;

	// A stop request holds off the next character; the shifter completes the
	// one in progress.
	assign tx_allow = ~(auto_cts & cts_int_n);

	// ======================================================================
	// Receive status.
	// ======================================================================
	reg  overrun_q;
	reg  fifo_err_q;
	reg  in_break_q;

	wire rx_overflow = rx_char_done & rx_fifo_full;
	wire dup_break   = rx_char_break & in_break_q;

	assign rx_fifo_write  = rx_char_done & ~rx_fifo_full & ~dup_break;
	assign xon_any_resume = modem_control_q[`UML_MC_XON_ANY] & rx_char_done;

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			overrun_q  <= 1'b0;
			fifo_err_q <= 1'b0;
			in_break_q <= 1'b0;
		end else begin
			if (rx_overflow) begin
				overrun_q <= 1'b1;
			end else if (rd_ls) begin
				overrun_q <= 1'b0;
			end
			if (rx_fifo_write & rx_char_error) begin
				fifo_err_q <= 1'b1;
			end else if (rd_ls) begin
				fifo_err_q <= 1'b0;
			end
			if (rx_char_done) begin
				in_break_q <= rx_char_break;
			end
		end
	end

	// ======================================================================
	// Transmit status.
	// ======================================================================
	reg thr_empty_q;

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			thr_empty_q <= 1'b1;
		end else if (fifo_mode) begin
			// A write in FIFO mode means the FIFO is no longer empty.
			if (thr_load) begin
				thr_empty_q <= 1'b0;
			end else if (tx_fifo_empty) begin
				thr_empty_q <= 1'b1;
			end
		end else begin
			if (thr_to_tsr) begin
				thr_empty_q <= 1'b1;
			end else if (thr_load) begin
				thr_empty_q <= 1'b0;
			end
		end
	end

	assign thr_irq_req = thr_empty_q & thr_irq_enable;

	assign line_status = {
		fifo_err_q,
		thr_empty_q & tsr_empty,
		thr_empty_q,
		rx_head_break,
		rx_head_framing,
		rx_head_parity,
		overrun_q,
		rx_data_present
	};

	// ======================================================================
	// Baud prescaler.
	// ======================================================================
	localparam [6:0] DIV_SHORT = `UML_PRESCALE_BASE;
	localparam [6:0] DIV_LONG  = `UML_PRESCALE_BASE * `UML_PRESCALE_EXTRA;

	reg  [6:0] pre_cnt_q;
	reg        tick_q;
	wire [6:0] div_last = (modem_control_q[`UML_MC_PRESCALE_FOUR] ? DIV_LONG : DIV_SHORT) - 7'h01;

	// Switching ratio mid-count may stretch one period; no tick is lost.
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			pre_cnt_q <= 7'h00;
			tick_q    <= 1'b0;
		end else if (pre_cnt_q >= div_last) begin
			pre_cnt_q <= 7'h00;
			tick_q    <= 1'b1;
		end else begin
			pre_cnt_q <= pre_cnt_q + 7'h01;
			tick_q    <= 1'b0;
		end
	end

	assign prescale_tick = tick_q;

endmodule

// file: placeholder_end.v
`timescale 1ns/1ps

// file: uml_checker.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checks of the modem and line status block.
// ==========================================================================
module uml_checker (
	input wire mclk,
	input wire reset,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire rx_char_done,
	input wire rx_char_break,
	input wire rx_fifo_full,
	input wire rx_fifo_write,
	input wire xon_any_resume,
	input wire bus_mode_16,
	input wire chan_irq_in,
	input wire chan_irq_out,
	input wire chan_irq_oe,
	input wire tx_serial,
	input wire ir_tx_pin,
	input wire thr_irq_enable,
	input wire thr_irq_req,
	input wire prescale_tick
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence seq_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Ticks come at least sixteen cycles apart, so eight quiet cycles after one is a safe lower bound.
	sequence seq_quiet;
		(!prescale_tick) [*8];
	endsequence
	a_ack_answer: assert property (seq_req |=> wb_ack_o) else $error("bus request not acknowledged");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_tick_spacing: assert property (prescale_tick |=> seq_quiet) else $error("prescale ticks too close");
	a_xon_any: assert property (xon_any_resume |-> rx_char_done) else $error("resume without char");
	a_overrun_drop: assert property (rx_char_done && rx_fifo_full |-> !rx_fifo_write)
		else $error("overrun stored");
	a_char_stored: assert property (rx_char_done && !rx_fifo_full && !rx_char_break |-> rx_fifo_write)
		else $error("good char not stored");
	a_irq_drive: assert property (!bus_mode_16 |-> chan_irq_oe && chan_irq_out == chan_irq_in)
		else $error("interrupt pin not driven");
	a_ir_idle: assert property (ir_tx_pin |-> !tx_serial) else $error("infrared output not idle");
	a_thr_irq: assert property (thr_irq_req |-> thr_irq_enable) else $error("holding irq while disabled");
endmodule

// file: uml_modem_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Peripheral on the handshake lines.
// ==========================================================================
module uml_modem_model (
	input  wire       mclk,
	input  wire       terminal_ready_n,
	input  wire [2:0] want,
	output reg        clear_to_send_n  = 1'b1,
	output reg        data_set_ready_n = 1'b1,
	output reg        ring_indicate_n  = 1'b1,
	output reg        carrier_detect_n = 1'b1
);
	// A modem answers terminal ready with data set ready; the bench steers the other lines.
	always @(posedge mclk) begin
		clear_to_send_n  <= ~want[0];
		data_set_ready_n <= terminal_ready_n;
		ring_indicate_n  <= ~want[1];
		carrier_detect_n <= ~want[2];
	end
endmodule

// file: uml_core_tb.sv
`timescale 1ns/1ps
`include "uml_regs.vh"
// ==========================================================================
// Bench for the modem and line status block.
// ==========================================================================
module uml_core_tb;
	localparam [7:0] r_mc = `UML_ADR_MODEM_CONTROL, r_ls = `UML_ADR_LINE_STATUS;
	localparam [7:0] r_ms = `UML_ADR_MODEM_STATUS, r_sc = `UML_ADR_SCRATCH, r_ef = `UML_ADR_ENH_FEATURE;
	reg        mclk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	reg [7:0]  wb_adr_i = 8'h00;
	reg [3:0]  wb_sel_i = 4'hf;
	reg [31:0] wb_dat_i = 32'h0;
	reg        rx_pin = 1'b1, ir_rx_pin = 1'b0, bus_mode_16 = 1'b0, chan_irq_in = 1'b1, tx_serial = 1'b1;
	reg        fifo_mode = 1'b0, rx_data_present = 1'b0, rx_char_done = 1'b0, rx_char_break = 1'b0;
	reg        rx_char_error = 1'b0, rx_fifo_full = 1'b0, rx_head_parity = 1'b0, rx_head_framing = 1'b0;
	reg        rx_head_break = 1'b0, rx_rts_stop = 1'b0, thr_load = 1'b0, thr_to_tsr = 1'b0;
	reg        tx_fifo_empty = 1'b1, tsr_empty = 1'b1, thr_irq_enable = 1'b1;
	reg [2:0]  want = 3'h0;
	wire [31:0] wb_dat_o;
	wire       wb_ack_o, clear_to_send_n, data_set_ready_n, ring_indicate_n, carrier_detect_n;
	wire       terminal_ready_n, request_to_send_n, user_output_one_n, user_output_two_n, tx_pin, ir_tx_pin;
	wire       chan_irq_out, chan_irq_oe, rx_serial, rx_fifo_write, xon_any_resume, thr_irq_req;
	wire       tx_allow, msr_irq_req, prescale_tick;
	integer    err_count = 0, checks = 0, g;
	reg [7:0]  d;
	reg [3:0]  sel_v = 4'hf;
	wire [7:0] hs_pins = {3'h0, chan_irq_oe, terminal_ready_n, request_to_send_n, user_output_one_n,
		user_output_two_n};

	uml_core DUT (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .clear_to_send_n, .data_set_ready_n, .ring_indicate_n, .carrier_detect_n, .terminal_ready_n,
		.request_to_send_n, .user_output_one_n, .user_output_two_n, .rx_pin, .ir_rx_pin, .tx_pin, .ir_tx_pin,
		.bus_mode_16, .chan_irq_in, .chan_irq_out, .chan_irq_oe, .tx_serial, .rx_serial, .fifo_mode,
		.rx_data_present, .rx_char_done, .rx_char_break, .rx_char_error, .rx_fifo_full, .rx_head_parity,
		.rx_head_framing, .rx_head_break, .rx_rts_stop, .rx_fifo_write, .xon_any_resume, .thr_load, .thr_to_tsr,
		.tx_fifo_empty, .tsr_empty, .thr_irq_enable, .thr_irq_req, .tx_allow, .msr_irq_req, .prescale_tick);
	uml_modem_model u_modem (.mclk, .terminal_ready_n, .want, .clear_to_send_n, .data_set_ready_n,
		.ring_indicate_n, .carrier_detect_n);

	always #50 mclk = ~mclk;

	task finish_test;
		begin
			$display("checks %0d mismatches %0d", checks, err_count);
			if (err_count == 0 && checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	task chk(input [7:0] seen, input [7:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// One classic cycle; the request holds until ack is sampled high at a rising edge.
	task wb(input w, input [7:0] a, input [7:0] v, output [7:0] q);
		integer n;
		begin
			@(posedge mclk);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_sel_i <= sel_v;
			wb_dat_i <= {24'h0, v};
			n = 0;
			do begin
				@(posedge mclk);
				n = n + 1;
			end while (wb_ack_o !== 1'b1 && n < 20);
			q = wb_dat_o[7:0];
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
			if (wb_ack_o !== 1'b1) begin
				err_count = err_count + 1;
				$display("mismatch at %0t: no ack", $time);
				finish_test;
			end
		end
	endtask

	task wr(input [7:0] a, input [7:0] v);
		wb(1'b1, a, v, d);
	endtask

	task rc(input [7:0] a, input [7:0] exp);
		begin
			wb(1'b0, a, 8'h00, d);
			chk(d, exp);
		end
	endtask

	// Sixteen-cycle wait covers the pin synchronisers and the change flags.
	task settle;
		repeat (16) @(posedge mclk);
	endtask

	task gap;
		integer n;
		begin
			// Sampling only at falling edges keeps the search clear of the tick's own launch edge.
			n = 0;
			do begin
				@(negedge mclk);
				n = n + 1;
			end while (prescale_tick !== 1'b1 && n < 200);
			g = 0;
			do begin
				@(negedge mclk);
				g = g + 1;
			end while (prescale_tick !== 1'b1 && g < 200);
			@(posedge mclk);
			if (n >= 200 || g >= 200) begin
				err_count = err_count + 1;
				$display("mismatch at %0t: no prescale tick", $time);
				finish_test;
			end
		end
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		rc(r_mc, 8'h00);
		rc(r_ls, 8'h60);
		rc(r_ms, 8'h00);
		rc(r_sc, 8'h00);
		$display("test reset values done");
		bus_mode_16 <= 1'b1;
		wr(r_mc, 8'h0f);
		@(negedge mclk);
		chk(hs_pins, 8'h10);
		wr(r_mc, 8'h00);
		@(negedge mclk);
		chk(hs_pins, 8'h0f);
		wr(r_sc, 8'ha5);
		bus_mode_16 <= 1'b0;
		sel_v = 4'he;
		wr(r_sc, 8'h5a);
		sel_v = 4'hf;
		rc(r_sc, 8'ha5);
		rc(8'h14, 8'h00);
		$display("test control and scratch done");
		want <= 3'b001;
		settle;
		@(negedge mclk);
		chk({7'h0, msr_irq_req}, 8'h01);
		// The modem echoed the two terminal-ready toggles above, so the ready change is set too.
		rc(r_ms, 8'h13);
		@(negedge mclk);
		chk({7'h0, msr_irq_req}, 8'h00);
		rc(r_ms, 8'h10);
		want <= 3'b011;
		settle;
		rc(r_ms, 8'h50);
		want <= 3'b001;
		settle;
		rc(r_ms, 8'h14);
		want <= 3'b101;
		wr(r_mc, 8'h01);
		settle;
		rc(r_ms, 8'hba);
		$display("test modem inputs done");
		wr(r_mc, 8'h1f);
		tx_serial <= 1'b0;
		settle;
		rc(r_ms, 8'hf0);
		@(negedge mclk);
		chk({3'h0, rx_serial, tx_pin, terminal_ready_n, request_to_send_n, user_output_one_n}, 8'h0f);
		wr(r_mc, 8'h10);
		settle;
		rc(r_ms, 8'h0f);
		tx_serial <= 1'b1;
		wr(r_mc, 8'h00);
		settle;
		rc(r_ms, 8'h99);
		$display("test loop-back done");
		wr(r_ef, 8'h80);
		want <= 3'b000;
		settle;
		@(negedge mclk);
		chk({7'h0, tx_allow}, 8'h00);
		wr(r_ef, 8'h40);
		@(negedge mclk);
		chk({7'h0, tx_allow}, 8'h01);
		wr(r_mc, 8'h02);
		rx_rts_stop <= 1'b1;
		rx_pin <= 1'b0;
		@(negedge mclk);
		chk({7'h0, request_to_send_n}, 8'h01);
		@(posedge mclk);
		rx_rts_stop <= 1'b0;
		@(negedge mclk);
		chk({7'h0, request_to_send_n}, 8'h00);
		wr(r_mc, 8'h20);
		rx_char_done <= 1'b1;
		rx_char_error <= 1'b1;
		@(posedge mclk);
		rx_char_error <= 1'b0;
		rx_fifo_full <= 1'b1;
		@(posedge mclk);
		rx_char_done <= 1'b0;
		rx_fifo_full <= 1'b0;
		{rx_data_present, rx_head_parity, rx_head_framing, rx_head_break} <= 4'hf;
		rc(r_ls, 8'hff);
		{rx_data_present, rx_head_parity, rx_head_framing, rx_head_break} <= 4'h0;
		rc(r_ls, 8'h60);
		thr_load <= 1'b1;
		tsr_empty <= 1'b0;
		@(posedge mclk);
		thr_load <= 1'b0;
		rc(r_ls, 8'h00);
		@(negedge mclk);
		chk({7'h0, thr_irq_req}, 8'h00);
		@(posedge mclk);
		thr_to_tsr <= 1'b1;
		@(posedge mclk);
		thr_to_tsr <= 1'b0;
		rc(r_ls, 8'h20);
		@(negedge mclk);
		chk({7'h0, thr_irq_req}, 8'h01);
		@(posedge mclk);
		tsr_empty <= 1'b1;
		rc(r_ls, 8'h60);
		// Two break characters in a row: only the first may enter the FIFO.
		rx_char_done <= 1'b1;
		rx_char_break <= 1'b1;
		@(negedge mclk);
		chk({6'h0, xon_any_resume, rx_fifo_write}, 8'h03);
		@(negedge mclk);
		chk({6'h0, xon_any_resume, rx_fifo_write}, 8'h02);
		@(posedge mclk);
		rx_char_done <= 1'b0;
		rx_char_break <= 1'b0;
		// In FIFO mode a load in the same cycle as an empty FIFO leaves the flag clear.
		fifo_mode <= 1'b1;
		thr_load <= 1'b1;
		@(posedge mclk);
		thr_load <= 1'b0;
		tx_fifo_empty <= 1'b0;
		rc(r_ls, 8'h00);
		tx_fifo_empty <= 1'b1;
		rc(r_ls, 8'h60);
		fifo_mode <= 1'b0;
		$display("test line status done");
		wr(r_mc, 8'h40);
		tx_serial <= 1'b0;
		@(negedge mclk);
		chk({5'h0, rx_serial, ir_tx_pin, tx_pin}, 8'h07);
		@(posedge mclk);
		tx_serial <= 1'b1;
		@(negedge mclk);
		chk({5'h0, rx_serial, ir_tx_pin, tx_pin}, 8'h05);
		gap;
		chk(g[7:0], 8'h10);
		wr(r_mc, 8'h80);
		gap;
		gap;
		chk(g[7:0], 8'h40);
		$display("test infrared and prescaler done");
		finish_test;
	end
endmodule

bind uml_core uml_checker u_chk (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_char_done, .rx_char_break,
	.rx_fifo_full, .rx_fifo_write, .xon_any_resume, .bus_mode_16, .chan_irq_in, .chan_irq_out, .chan_irq_oe,
	.tx_serial, .ir_tx_pin, .thr_irq_enable, .thr_irq_req, .prescale_tick);
